// ===== verilog/pxr_pkg.sv
package pxr_pkg;
   // ****************************************
   // Register numbers on the management bus
   // ****************************************
   localparam logic [4:0] PXR_ADDR_EXPANSION = 5'h06;
   localparam logic [4:0] PXR_ADDR_VENDOR = 5'h10;
   localparam logic [4:0] PXR_ADDR_SPECIAL = 5'h11;
   localparam int PXR_ADDR_W = 5;
   localparam int PXR_DATA_W = 16;

   // ****************************************
   // Expansion register fields
   // ****************************************
   localparam int PXR_EXP_PD_FAULT = 4;
   localparam int PXR_EXP_LP_NP_ABLE = 3;
   localparam int PXR_EXP_NP_ABLE = 2;
   localparam int PXR_EXP_PAGE_RX = 1;
   localparam int PXR_EXP_LP_AN_ABLE = 0;

   // ****************************************
   // Vendor status and control fields
   // ****************************************
   localparam int PXR_VSC_FLOW_EN = 15;
   localparam int PXR_VSC_RSVD_RW = 14;
   localparam int PXR_VSC_CRS_DISC = 13;
   localparam int PXR_VSC_TX_FLOW = 12;
   localparam int PXR_VSC_IN_SYNC = 11;
   localparam int PXR_VSC_PD_100 = 10;
   localparam int PXR_VSC_PD_10 = 9;
   localparam int PXR_VSC_POLARITY = 8;
   localparam int PXR_VSC_T4 = 2;
   localparam int PXR_VSC_SPEED = 1;
   localparam int PXR_VSC_DUPLEX = 0;
   // Writable bits of the vendor register
   localparam logic [15:0] PXR_VSC_WMASK = 16'hf000;

   // ****************************************
   // Special control fields
   // ****************************************
   localparam int PXR_STC_SCR_BYP = 15;
   localparam int PXR_STC_ENC_BYP = 14;
   localparam int PXR_STC_H_PAT = 13;
   localparam int PXR_STC_PAT34 = 12;
   localparam int PXR_STC_GOOD_LINK = 11;
   localparam int PXR_STC_TX_CRS_DIS = 9;
   localparam int PXR_STC_DYN_PD_DIS = 8;
   localparam int PXR_STC_AN_LOOP = 7;
   localparam int PXR_STC_TRISTATE = 6;
   localparam int PXR_STC_FILT_BYP = 5;
   localparam int PXR_STC_APOL_DIS = 4;
   localparam int PXR_STC_SQ_DIS = 3;
   localparam int PXR_STC_EXT_SQ = 2;
   localparam int PXR_STC_LINK_DIS = 1;
   localparam int PXR_STC_JAB_DIS = 0;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [15:0] PXR_EXP_RESET = 16'h0000;
   localparam logic [15:0] PXR_VSC_RESET = 16'h0000;
   localparam logic [15:0] PXR_STC_RESET = 16'h0000;
   localparam logic [15:0] PXR_ZERO = 16'h0000;
endpackage : pxr_pkg

// ===== verilog/pxr_flag_if.sv
`timescale 1ns/1ps
interface pxr_flag_if;
   logic set;
   logic clr;
   logic flag;
   modport owner (input set, input clr, output flag);
   modport user (output set, output clr, input flag);
endinterface : pxr_flag_if

// ===== verilog/pxr_latch_flag.sv
`timescale 1ns/1ps
module pxr_latch_flag (
   input wire logic mclk,
   input wire logic srst,
   pxr_flag_if.owner fl
);
   logic flag_q;
   logic flag_d;

   // Set beats clear so an event during the clearing read survives
   assign flag_d = fl.set | (flag_q & ~fl.clr);
   assign fl.flag = flag_q;

   always_ff @(posedge mclk) begin
      if (srst) begin
         flag_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
      end
   end
endmodule : pxr_latch_flag

// ===== verilog/pxr_regs.sv
`timescale 1ns/1ps
// Overview of operation
// - Parallel-detection fault latches high at expansion bit 4, cleared by read.
// - Page-received latches high at expansion bit 1, cleared by read.
// - Expansion bits 3, 2, 0 show next-page and autoneg abilities, reset 0.
// - Reserved expansion 15:5 and vendor 7:3 read zero; writes ignored.
// - Vendor bit 15 enables vendor flow control; read-write, reset 0.
// - Vendor bit 13 enables carrier-sense disconnect; reset depends on mode.
// - Vendor bit 12 enables transmit flow control; read-write, reset 0.
// - Vendor bits 11..8 report sync, power-down and reversed polarity.
// - Vendor bits 2..0 report T4, speed and duplex outcome.
// - Special bits 15, 14 bypass scrambler and 4B/5B coding.
// - Special bits 13, 12 force H pattern and 34 pattern.
// - Special bit 11 forces 100BASE-TX link good.
// - Special bit 9 disables carrier sense from own transmissions.
// - Special bit 8 disables dynamic power-down.
// - Special bit 7 puts auto-negotiation in loopback.
// - Special bit 6 tri-states the line transmit drivers.
// - Special bit 5 bypasses receive filter; bit 4 disables auto polarity.
// - Special bit 3 disables squelch test; bit 2 enables extended squelch.
// - Special bit 1 disables link integrity; bit 0 disables jabber.
module pxr_regs (
   mclk,
   srst,
   repeater_mode,
   reg_addr,
   reg_wr,
   reg_rd,
   reg_wdata,
   reg_rdata,
   reg_rvalid,
   pd_fault_evt,
   page_rx_evt,
   lp_np_able,
   np_able,
   lp_an_able,
   rx_in_sync,
   pd_100,
   pd_10,
   pol_reversed,
   res_t4,
   res_speed,
   res_duplex,
   flow_en,
   crs_disc_en,
   tx_flow_en,
   scr_bypass,
   enc_bypass,
   tx_h_pattern,
   tx_pattern34,
   force_link_good,
   tx_crs_dis,
   dyn_pd_dis,
   an_loopback,
   tx_tristate,
   filt_bypass,
   auto_pol_dis,
   squelch_dis,
   ext_squelch_en,
   link_int_dis,
   jabber_dis
);
   import pxr_pkg::*;

   input wire logic mclk;
   input wire logic srst;
   input wire logic repeater_mode;
   input wire logic [pxr_pkg::PXR_ADDR_W-1:0] reg_addr;
   input wire logic reg_wr;
   input wire logic reg_rd;
   input wire logic [pxr_pkg::PXR_DATA_W-1:0] reg_wdata;
   output logic [pxr_pkg::PXR_DATA_W-1:0] reg_rdata;
   output logic reg_rvalid;
   input wire logic pd_fault_evt;
   input wire logic page_rx_evt;
   input wire logic lp_np_able;
   input wire logic np_able;
   input wire logic lp_an_able;
   input wire logic rx_in_sync;
   input wire logic pd_100;
   input wire logic pd_10;
   input wire logic pol_reversed;
   input wire logic res_t4;
   input wire logic res_speed;
   input wire logic res_duplex;
   output logic flow_en;
   output logic crs_disc_en;
   output logic tx_flow_en;
   output logic scr_bypass;
   output logic enc_bypass;
   output logic tx_h_pattern;
   output logic tx_pattern34;
   output logic force_link_good;
   output logic tx_crs_dis;
   output logic dyn_pd_dis;
   output logic an_loopback;
   output logic tx_tristate;
   output logic filt_bypass;
   output logic auto_pol_dis;
   output logic squelch_dis;
   output logic ext_squelch_en;
   output logic link_int_dis;
   output logic jabber_dis;

   // ****************************************
   // State
   // ****************************************
   typedef enum logic [0:0] {PXR_ST_RESET, PXR_ST_RUN} pxr_state_t;
   pxr_state_t state_q;
   logic [15:0] vsc_q;
   logic [15:0] vsc_d;
   logic [15:0] stc_q;
   logic [15:0] stc_d;
   logic [15:0] stat_q;
   logic [15:0] abil_q;
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;
   logic rvalid_q;
   logic [15:0] exp_word;
   logic [15:0] vsc_word;
   logic sel_exp;
   logic sel_vsc;
   logic sel_stc;
   logic rd_exp;

   pxr_flag_if fault_if ();
   pxr_flag_if page_if ();

   function automatic logic [15:0] pxr_merge(input logic [15:0] old_v,
                                             input logic [15:0] new_v,
                                             input logic [15:0] mask);
      pxr_merge = (old_v & ~mask) | (new_v & mask);
   endfunction : pxr_merge

   // ****************************************
   // Decode
   // ****************************************
   assign sel_exp = (reg_addr == PXR_ADDR_EXPANSION);
   assign sel_vsc = (reg_addr == PXR_ADDR_VENDOR);
   assign sel_stc = (reg_addr == PXR_ADDR_SPECIAL);
   assign rd_exp = reg_rd & sel_exp;

   // ****************************************
   // Latched-high flags, self clearing on read
   // ****************************************
   assign fault_if.set = pd_fault_evt;
   assign fault_if.clr = rd_exp;
   assign page_if.set = page_rx_evt;
   assign page_if.clr = rd_exp;

   pxr_latch_flag u_fault (
      .mclk(mclk),
      .srst(srst),
      .fl(fault_if)
   );

   pxr_latch_flag u_page (
      .mclk(mclk),
      .srst(srst),
      .fl(page_if)
   );

   // ****************************************
   // Read words
   // ****************************************
   // Status inputs are registered so read data never depends on a raw pin
   always_comb begin
      exp_word = PXR_ZERO;
      exp_word[PXR_EXP_PD_FAULT] = fault_if.flag;
      exp_word[PXR_EXP_LP_NP_ABLE] = abil_q[PXR_EXP_LP_NP_ABLE];
      exp_word[PXR_EXP_NP_ABLE] = abil_q[PXR_EXP_NP_ABLE];
      exp_word[PXR_EXP_PAGE_RX] = page_if.flag;
      exp_word[PXR_EXP_LP_AN_ABLE] = abil_q[PXR_EXP_LP_AN_ABLE];
   end

   always_comb begin
      vsc_word = vsc_q & PXR_VSC_WMASK;
      vsc_word[PXR_VSC_IN_SYNC] = stat_q[PXR_VSC_IN_SYNC];
      vsc_word[PXR_VSC_PD_100] = stat_q[PXR_VSC_PD_100];
      vsc_word[PXR_VSC_PD_10] = stat_q[PXR_VSC_PD_10];
      vsc_word[PXR_VSC_POLARITY] = stat_q[PXR_VSC_POLARITY];
      vsc_word[PXR_VSC_T4] = stat_q[PXR_VSC_T4];
      vsc_word[PXR_VSC_SPEED] = stat_q[PXR_VSC_SPEED];
      vsc_word[PXR_VSC_DUPLEX] = stat_q[PXR_VSC_DUPLEX];
   end

   // Unmapped numbers read as zero
   assign rdata_d = sel_exp ? exp_word :
                    sel_vsc ? vsc_word :
                    sel_stc ? stc_q :
                    PXR_ZERO;

   // Reserved writable bit 14 is stored as written; software keeps it zero
   assign vsc_d = (reg_wr & sel_vsc) ?
                  pxr_merge(vsc_q, reg_wdata, PXR_VSC_WMASK) : vsc_q;
   assign stc_d = (reg_wr & sel_stc) ? reg_wdata : stc_q;

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge mclk) begin
      if (srst) begin
         state_q <= PXR_ST_RESET;
      end else begin
         state_q <= PXR_ST_RUN;
      end
   end

   // Disconnect default is taken from the mode strap in the cycle after reset
   always_ff @(posedge mclk) begin
      if (srst) begin
         vsc_q <= PXR_VSC_RESET;
      end else begin
         case (state_q)
            PXR_ST_RESET: begin
               vsc_q <= vsc_d;
               vsc_q[PXR_VSC_CRS_DISC] <= repeater_mode;
            end
            PXR_ST_RUN: begin
               vsc_q <= vsc_d;
            end
            default: begin
               vsc_q <= vsc_d;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         stc_q <= PXR_STC_RESET;
      end else begin
         stc_q <= stc_d;
      end
   end

   // ****************************************
   // Status sampling
   // ****************************************
   // A status change is readable one cycle after it reaches the pins
   always_ff @(posedge mclk) begin
      if (srst) begin
         stat_q <= PXR_ZERO;
      end else begin
         stat_q <= {4'h0, rx_in_sync, pd_100, pd_10, pol_reversed,
                    5'h00, res_t4, res_speed, res_duplex};
      end
   end

   // Abilities sit apart: bits 2 and 0 mean different things in each word
   always_ff @(posedge mclk) begin
      if (srst) begin
         abil_q <= PXR_EXP_RESET;
      end else begin
         abil_q <= {12'h000, lp_np_able, np_able, 1'b0, lp_an_able};
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         rdata_q <= PXR_ZERO;
      end else begin
         rdata_q <= reg_rd ? rdata_d : rdata_q;
      end
   end

   // One-cycle answer strobe for every accepted read
   always_ff @(posedge mclk) begin
      if (srst) begin
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= reg_rd;
      end
   end

   assign reg_rdata = rdata_q;
   assign reg_rvalid = rvalid_q;

   // ****************************************
   // Control outputs, straight from flip-flops
   // ****************************************
   assign flow_en = vsc_q[PXR_VSC_FLOW_EN];
   assign crs_disc_en = vsc_q[PXR_VSC_CRS_DISC];
   assign tx_flow_en = vsc_q[PXR_VSC_TX_FLOW];
   assign scr_bypass = stc_q[PXR_STC_SCR_BYP];
   assign enc_bypass = stc_q[PXR_STC_ENC_BYP];
   assign tx_h_pattern = stc_q[PXR_STC_H_PAT];
   assign tx_pattern34 = stc_q[PXR_STC_PAT34];
   assign force_link_good = stc_q[PXR_STC_GOOD_LINK];
   assign tx_crs_dis = stc_q[PXR_STC_TX_CRS_DIS];
   assign dyn_pd_dis = stc_q[PXR_STC_DYN_PD_DIS];
   assign an_loopback = stc_q[PXR_STC_AN_LOOP];
   assign tx_tristate = stc_q[PXR_STC_TRISTATE];
   assign filt_bypass = stc_q[PXR_STC_FILT_BYP];
   assign auto_pol_dis = stc_q[PXR_STC_APOL_DIS];
   assign squelch_dis = stc_q[PXR_STC_SQ_DIS];
   assign ext_squelch_en = stc_q[PXR_STC_EXT_SQ];
   assign link_int_dis = stc_q[PXR_STC_LINK_DIS];
   assign jabber_dis = stc_q[PXR_STC_JAB_DIS];
endmodule : pxr_regs

// ===== testbench/pxr_regs_monitor.sv
`timescale 1ns/1ps
// ****************************************
// Port checks of the register bank
// ****************************************
module pxr_regs_monitor
   import pxr_pkg::*;
(
   mclk,
   srst,
   reg_addr,
   reg_wr,
   reg_rd,
   reg_wdata,
   reg_rdata,
   pd_fault_evt,
   page_rx_evt,
   np_able,
   res_t4,
   flow_en,
   tx_flow_en,
   scr_bypass,
   jabber_dis
);
   input wire logic mclk, srst, reg_wr, reg_rd, pd_fault_evt, page_rx_evt;
   input wire logic flow_en, tx_flow_en, scr_bypass, jabber_dis;
   input wire logic np_able;
   input wire logic res_t4;
   input wire logic [pxr_pkg::PXR_ADDR_W-1:0] reg_addr;
   input wire logic [pxr_pkg::PXR_DATA_W-1:0] reg_wdata;
   input wire logic [pxr_pkg::PXR_DATA_W-1:0] reg_rdata;
   wire rd6 = reg_rd && reg_addr == PXR_ADDR_EXPANSION;
   wire evt = pd_fault_evt || page_rx_evt;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   rst_zero_a: assert property (disable iff (1'b0) srst |=> !scr_bypass && !flow_en)
      else $error("controls not cleared by reset");
   pdf_set_a: assert property (pd_fault_evt ##1 !reg_rd ##1 rd6 |=> reg_rdata[4])
      else $error("fault flag lost");
   page_set_a: assert property (page_rx_evt ##1 !reg_rd ##1 rd6 |=> reg_rdata[1])
      else $error("page flag lost");
   flag_clr_a: assert property ((rd6 && !evt) ##1 (!reg_rd && !evt) ##1 (rd6 && !evt)
      |=> !reg_rdata[4] && !reg_rdata[1]) else $error("flag not cleared by read");
   rd_evt_a: assert property ((rd6 && page_rx_evt) ##1 !reg_rd ##1 rd6 |=> reg_rdata[1])
      else $error("event during read lost");
   rsvd_exp_a: assert property (rd6 |=> reg_rdata[15:5] == 11'h000)
      else $error("expansion reserved bits set");
   rsvd_vend_a: assert property (reg_rd && reg_addr == PXR_ADDR_VENDOR |=> reg_rdata[7:3] == 5'h00)
      else $error("vendor reserved bits set");
   spec_wr_a: assert property (reg_wr && reg_addr == PXR_ADDR_SPECIAL |=>
      scr_bypass == $past(reg_wdata[15]) && jabber_dis == $past(reg_wdata[0]))
      else $error("special write not applied");
   vend_wr_a: assert property (reg_wr && reg_addr == PXR_ADDR_VENDOR |=>
      flow_en == $past(reg_wdata[15]) && tx_flow_en == $past(reg_wdata[12]))
      else $error("vendor write not applied");
   ctl_hold_a: assert property (!reg_wr |=> $stable(scr_bypass) && $stable(flow_en))
      else $error("control changed without write");
   abil_rd_a: assert property (rd6 |=> reg_rdata[2] == $past(np_able, 2))
      else $error("next page ability misread");
   t4_rd_a: assert property (reg_rd && reg_addr == PXR_ADDR_VENDOR |=>
      reg_rdata[2] == $past(res_t4, 2)) else $error("T4 result misread");
   cover property (reg_wr && reg_addr == PXR_ADDR_SPECIAL);
   cover property (pd_fault_evt ##1 !reg_rd ##1 rd6);
   cover property (rd6 && page_rx_evt);
endmodule : pxr_regs_monitor
bind pxr_regs pxr_regs_monitor u_mon (.*);

// ===== testbench/pxr_mgmt_model.sv
`timescale 1ns/1ps
// ****************************************
// Station management side
// ****************************************
module pxr_mgmt_model
   import pxr_pkg::*;
(
   mclk,
   reg_addr,
   reg_wr,
   reg_rd,
   reg_wdata,
   reg_rdata,
   reg_rvalid
);
   input wire logic mclk, reg_rvalid;
   input wire logic [15:0] reg_rdata;
   output logic [4:0] reg_addr;
   output logic reg_wr, reg_rd;
   output logic [15:0] reg_wdata;
   initial begin
      reg_addr = 5'h1f;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 16'h0000;
   end
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(negedge mclk);
      reg_addr = a;
      reg_wdata = (a == PXR_ADDR_VENDOR) ? d & 16'hbfff :
         (a == PXR_ADDR_SPECIAL) ? d & 16'hfbff : d;
      reg_wr = 1'b1;
      @(negedge mclk);
      reg_wr = 1'b0;
      // Idle lines never keep the last value
      reg_addr = ~a;
      reg_wdata = ~reg_wdata;
   endtask : wr
   task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic ok);
      @(negedge mclk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge mclk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      ok = (reg_rvalid === 1'b1);
      d = reg_rdata;
   endtask : rd
endmodule : pxr_mgmt_model

// ===== testbench/pxr_regs_tb.sv
`timescale 1ns/1ps
// ****************************************
// Register bank regression
// ****************************************
module pxr_regs_tb;
   import pxr_pkg::*;
   typedef struct {logic [4:0] a; logic [15:0] w; logic [15:0] r;} pxr_row_t;
   logic mclk, srst, rpt, pdf, prx, reg_wr, reg_rd, reg_rvalid, ok;
   logic [9:0] st;
   logic [4:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, v16, v17, got;
   wire [17:0] ctl;
   int n_fail, checked;
   pxr_row_t rows [8] = '{'{5'h11, 16'hffff, 16'hfbff}, '{5'h11, 16'h5555, 16'h5155},
      '{5'h11, 16'haaaa, 16'haaaa}, '{5'h10, 16'hffff, 16'hb000}, '{5'h10, 16'h1000, 16'h1000},
      '{5'h10, 16'ha000, 16'ha000}, '{5'h07, 16'hffff, 16'h0000}, '{5'h06, 16'hffff, 16'h0000}};
   pxr_regs dut (.mclk(mclk), .srst(srst), .repeater_mode(rpt), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .pd_fault_evt(pdf), .page_rx_evt(prx), .lp_np_able(st[9]),
      .np_able(st[8]), .lp_an_able(st[7]), .rx_in_sync(st[6]), .pd_100(st[5]), .pd_10(st[4]),
      .pol_reversed(st[3]), .res_t4(st[2]), .res_speed(st[1]), .res_duplex(st[0]),
      .flow_en(ctl[17]), .crs_disc_en(ctl[16]), .tx_flow_en(ctl[15]), .scr_bypass(ctl[14]),
      .enc_bypass(ctl[13]), .tx_h_pattern(ctl[12]), .tx_pattern34(ctl[11]),
      .force_link_good(ctl[10]), .tx_crs_dis(ctl[9]), .dyn_pd_dis(ctl[8]),
      .an_loopback(ctl[7]), .tx_tristate(ctl[6]), .filt_bypass(ctl[5]),
      .auto_pol_dis(ctl[4]), .squelch_dis(ctl[3]), .ext_squelch_en(ctl[2]),
      .link_int_dis(ctl[1]), .jabber_dis(ctl[0]));
   pxr_mgmt_model mgr (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   task automatic test_done;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : test_done
   task automatic chk_w(input logic [15:0] g, input logic [15:0] e);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %0t word %h want %h", $time, g, e);
      end
   endtask : chk_w
   task automatic chk_c(input logic [17:0] g, input logic [17:0] e);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %0t controls %h want %h", $time, g, e);
      end
   endtask : chk_c
   task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
      mgr.rd(a, got, ok);
      if (ok !== 1'b1) begin
         n_fail++;
         $display("[ERR] %0t read not answered", $time);
         test_done();
      end
      chk_w(got, e);
   endtask : rd_chk
   function automatic logic [17:0] exp_ctl();
      return {v16[15], v16[13:12], v17[15:11], v17[9:0]};
   endfunction : exp_ctl
   task automatic do_reset(input logic r);
      srst = 1'b1;
      rpt = r;
      repeat (5) @(negedge mclk);
      srst = 1'b0;
      repeat (2) @(negedge mclk);
   endtask : do_reset
   initial begin
      {srst, rpt, pdf, prx} = 4'h8;
      st = 10'h000;
      v16 = 16'h0000;
      v17 = 16'h0000;
      n_fail = 0;
      checked = 0;
      do_reset(1'b0);
      rd_chk(PXR_ADDR_EXPANSION, 16'h0000);
      rd_chk(PXR_ADDR_VENDOR, 16'h0000);
      rd_chk(PXR_ADDR_SPECIAL, 16'h0000);
      chk_c(ctl, exp_ctl());
      $display("test reset values done");
      foreach (rows[i]) begin
         mgr.wr(rows[i].a, rows[i].w);
         if (rows[i].a == PXR_ADDR_VENDOR) v16 = rows[i].r;
         if (rows[i].a == PXR_ADDR_SPECIAL) v17 = rows[i].r;
         chk_c(ctl, exp_ctl());
         rd_chk(rows[i].a, rows[i].r);
      end
      $display("test register rows done");
      for (int i = 0; i < 10; i++) begin
         st = 10'h001 << i;
         rd_chk(PXR_ADDR_EXPANSION, {12'h000, st[9:8], 1'b0, st[7]});
         rd_chk(PXR_ADDR_VENDOR, {v16[15:12], st[6:3], 5'h00, st[2:0]});
      end
      st = 10'h000;
      $display("test status done");
      for (int k = 0; k < 2; k++) begin
         @(negedge mclk);
         {pdf, prx} = (k == 1) ? 2'b01 : 2'b10;
         @(negedge mclk);
         {pdf, prx} = 2'b00;
         rd_chk(PXR_ADDR_EXPANSION, (k == 1) ? 16'h0002 : 16'h0010);
         rd_chk(PXR_ADDR_EXPANSION, 16'h0000);
      end
      fork
         mgr.rd(PXR_ADDR_EXPANSION, got, ok);
         begin
            @(negedge mclk);
            prx = 1'b1;
            @(negedge mclk);
            prx = 1'b0;
         end
      join
      chk_w(got, 16'h0000);
      rd_chk(PXR_ADDR_EXPANSION, 16'h0002);
      rd_chk(PXR_ADDR_EXPANSION, 16'h0000);
      $display("test latched flags done");
      // Repeater strap turns the disconnect function on after reset
      do_reset(1'b1);
      v16 = 16'h2000;
      v17 = 16'h0000;
      chk_c(ctl, exp_ctl());
      rd_chk(PXR_ADDR_VENDOR, 16'h2000);
      $display("test repeater reset done");
      test_done();
   end
endmodule : pxr_regs_tb
